// file: hw/pin_cfg_regs.vh
`ifndef PIN_CFG_REGS_VH
`define PIN_CFG_REGS_VH
// Register indices as printed; byte address is four times the index
`define PINS_5_6_CONFIG_IDX 8'h20
`define PINS_7_8_CONFIG_IDX 8'h21
`define VIDEO_PATH_CONTROL_IDX 8'h22
// Reset values
`define PINS_5_6_CONFIG_RST 8'h00
`define PINS_7_8_CONFIG_RST 8'h00
`define VIDEO_PATH_CONTROL_RST 8'h00
// Pin field positions inside a 4-bit nibble
`define PIN_LEVEL_BIT 3
`define PIN_FAR_BIT 2
`define PIN_CODE_HI_BIT 1
`define PIN_CODE_LO_BIT 0
// Pin 7 has no low code bit; that position is reserved
`define PINS_7_8_WMASK 8'hFE
// Video path control field positions
`define VP_HOLD_BIT 7
`define VP_PASS_BIT 6
`define VP_POL_BIT 5
`define VP_AUDIO_OFF_BIT 4
`define VP_QUAD_OVR_BIT 3
`define VP_NARROW_BIT 2
`define VP_INBAND_BIT 1
`define VP_QUAD_EN_BIT 0
// Direction/enable codes {high, low}
`define CODE_FUNC_OUT 2'b00
`define CODE_TRISTATE 2'b10
`define CODE_PIN_OUT 2'b01
`define CODE_PIN_IN 2'b11
`endif

// file: hw/pin_sync3.v
`timescale 1ns/1ps
// Three-stage synchroniser; output changes once stages two and three agree
module pin_sync3 (
   input wire clk,
   input wire rst,
   input wire din,
   output reg dout
);
   reg s1_reg; // Metastability stage, read only by s2
   reg s2_reg;
   reg s3_reg;
   // Shift chain plus agreement filter
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            dout <= s3_reg;
         end
      end
   end
endmodule // pin_sync3

// file: hw/pin_ctrl.v
`timescale 1ns/1ps
`include "pin_cfg_regs.vh"
// One pin: resolves local level, far level and the 2-bit code into pad drive
module pin_ctrl (
   input wire clk,
   input wire rst,
   input wire [3:0] cfg,
   input wire far_level,
   input wire pad_in,
   output reg pad_out,
   output reg pad_oe_n,
   output wire pad_level
);
   wire local_level = cfg[`PIN_LEVEL_BIT];
   wire far_on = cfg[`PIN_FAR_BIT];
   wire [1:0] code = {cfg[`PIN_CODE_HI_BIT], cfg[`PIN_CODE_LO_BIT]};
   // Synchronised pad level out on pad_level; no register reads it back
   pin_sync3 u_sync (
      .clk(clk),
      .rst(rst),
      .din(pad_in),
      .dout(pad_level)
   );
   // Drive selection; oe_n low means driving
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_out <= 1'b0;
         pad_oe_n <= 1'b1;
      end else if (far_on) begin
         pad_out <= far_level;
         pad_oe_n <= 1'b0;
      end else begin
         // Far level ignored here
         case (code)
            `CODE_PIN_OUT: begin
               pad_out <= local_level;
               pad_oe_n <= 1'b0;
            end
            `CODE_FUNC_OUT: begin
               // Functional output not modelled; drives low
               pad_out <= 1'b0;
               pad_oe_n <= 1'b0;
            end
            default: begin
               // Tri-state and pin-mode input
               pad_out <= 1'b0;
               pad_oe_n <= 1'b1;
            end
         endcase
      end
   end
endmodule // pin_ctrl

// file: hw/pin_video_cfg.v
`timescale 1ns/1ps
`include "pin_cfg_regs.vh"
// Notes on behaviour
// - Local level drives pin in pin-output mode
// - Far control forces output with far value
// - Far values ignored when far control off
// - Code 00 func,10 tristate,01 out,11 in
// - Hold bit blocks forward-channel register loading
// - Lower bits auto-load from far end
// - Passthrough forwards colour regardless of valid
// - Passthrough disables protection and packet audio
// - Polarity bit selects active-low frame_valid
// - Audio-off bit keeps audio off video pins
// - Quad override takes enable from bit 0
// - Width bit selects 18 or 24 bit
// - Bit 0 enables four-channel audio when override bit 3 is set
// - Bit 1 selects in-band audio transport
module pin_video_cfg (
   input wire clk,
   input wire rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [3:0] far_pin_level,
   input wire far_cfg_valid,
   input wire [6:0] far_cfg_data,
   input wire [3:0] pad_in,
   output wire [3:0] pad_out,
   output wire [3:0] pad_oe_n,
   input wire frame_valid,
   output reg frame_valid_active,
   output reg colour_passthrough,
   output reg protection_enable,
   output reg packet_audio_enable,
   output reg audio_on_video_pins,
   output reg quad_audio_enable,
   output reg inband_audio,
   output reg narrow_video
);
   reg [7:0] pins_5_6_reg; // Pin 5 low nibble, pin 6 high nibble
   reg [7:0] pins_7_8_reg; // Pin 7 low nibble, pin 8 high nibble
   reg [7:0] video_path_reg; // Video path control
   reg [7:0] video_path_next;
   reg [7:0] rd_mux; // Read data selection
   reg addr_hit; // Address maps to a register
   wire [3:0] pad_level; // Synchronised pad levels
   wire [7:0] word_idx = paddr[9:2]; // Index is byte address over four
   wire aligned = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0);
   wire access = psel && penable && pready;
   wire wr_strobe = access && pwrite && addr_hit;
   // Register decode
   always @* begin
      addr_hit = aligned;
      rd_mux = 8'h00;
      case (word_idx)
         `PINS_5_6_CONFIG_IDX: rd_mux = pins_5_6_reg;
         `PINS_7_8_CONFIG_IDX: rd_mux = pins_7_8_reg;
         `VIDEO_PATH_CONTROL_IDX: rd_mux = video_path_reg;
         default: addr_hit = 1'b0;
      endcase
      if (!aligned) begin
         rd_mux = 8'h00;
      end
   end
   // No wait state: pready rises in the first access cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel && !pready;
         pslverr <= psel && !pready && !addr_hit;
         if (psel && !pready && !pwrite) begin
            prdata <= {24'h0, rd_mux};
         end else if (!psel) begin
            prdata <= 32'h0;
         end
      end
   end
   // Pin configuration registers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pins_5_6_reg <= `PINS_5_6_CONFIG_RST;
         pins_7_8_reg <= `PINS_7_8_CONFIG_RST;
      end else if (wr_strobe) begin
         if (word_idx == `PINS_5_6_CONFIG_IDX) begin
            pins_5_6_reg <= pwdata[7:0];
         end
         if (word_idx == `PINS_7_8_CONFIG_IDX) begin
            pins_7_8_reg <= pwdata[7:0] & `PINS_7_8_WMASK;
         end
      end
   end
   // Video path next value: local write first, far load unless held
   always @* begin
      video_path_next = video_path_reg;
      if (wr_strobe && word_idx == `VIDEO_PATH_CONTROL_IDX) begin
         video_path_next = pwdata[7:0];
      end
      // Far load wins over a same-cycle local write of the lower bits
      if (far_cfg_valid && !video_path_next[`VP_HOLD_BIT]) begin
         video_path_next[6:0] = far_cfg_data;
      end
   end
   // Video path register
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         video_path_reg <= `VIDEO_PATH_CONTROL_RST;
      end else begin
         video_path_reg <= video_path_next;
      end
   end
   // Per-pin drive logic
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_pin
         wire [3:0] nib = (g == 0) ? pins_5_6_reg[3:0] :
                          (g == 1) ? pins_5_6_reg[7:4] :
                          (g == 2) ? pins_7_8_reg[3:0] : pins_7_8_reg[7:4];
         pin_ctrl u_pin (
            .clk(clk),
            .rst(rst),
            .cfg(nib),
            .far_level(far_pin_level[g]),
            .pad_in(pad_in[g]),
            .pad_out(pad_out[g]),
            .pad_oe_n(pad_oe_n[g]),
            .pad_level(pad_level[g])
         );
      end
   endgenerate
   // Datapath decode outputs
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         frame_valid_active <= 1'b0;
         colour_passthrough <= 1'b0;
         protection_enable <= 1'b1;
         packet_audio_enable <= 1'b1;
         audio_on_video_pins <= 1'b1;
         quad_audio_enable <= 1'b0;
         inband_audio <= 1'b0;
         narrow_video <= 1'b0;
      end else begin
         // Polarity inverts the incoming valid; same-clock input
         frame_valid_active <= frame_valid ^ video_path_reg[`VP_POL_BIT];
         colour_passthrough <= video_path_reg[`VP_PASS_BIT];
         protection_enable <= !video_path_reg[`VP_PASS_BIT];
         packet_audio_enable <= !video_path_reg[`VP_PASS_BIT];
         // Passthrough also blocks packet audio on video pins
         audio_on_video_pins <= !video_path_reg[`VP_AUDIO_OFF_BIT] &&
                                !video_path_reg[`VP_PASS_BIT];
         quad_audio_enable <= video_path_reg[`VP_QUAD_OVR_BIT] &&
                              video_path_reg[`VP_QUAD_EN_BIT];
         inband_audio <= video_path_reg[`VP_INBAND_BIT];
         narrow_video <= video_path_reg[`VP_NARROW_BIT];
      end
   end
endmodule // pin_video_cfg

// file: verif/pin_video_cfg_asserts.sv
`timescale 1ns/1ps
`include "pin_cfg_regs.vh"
// Port watcher; the hold bit is mirrored from bus writes
module pin_video_cfg_asserts (
   input logic clk,
   input logic rst,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic pready,
   input logic pslverr,
   input logic [31:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic far_cfg_valid,
   input logic [6:0] far_cfg_data,
   input logic colour_passthrough,
   input logic protection_enable,
   input logic packet_audio_enable,
   input logic audio_on_video_pins,
   input logic inband_audio,
   input logic narrow_video
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic hold_reg; // Mirrored hold bit
   logic wr_vp; // Bus write to video path control lands now
   logic hold_next; // Hold bit as a same-edge far load sees it
   assign wr_vp = psel && penable && pready && pwrite && paddr == `VIDEO_PATH_CONTROL_IDX * 4;
   assign hold_next = wr_vp ? pwdata[`VP_HOLD_BIT] : hold_reg;
   // Far loads never touch bit 7, so only writes move it
   always @(posedge clk or posedge rst) begin
      if (rst) hold_reg <= 1'b0;
      else hold_reg <= hold_next;
   end
   sequence s_far_take;
      far_cfg_valid && !hold_next;
   endsequence
   // Register one edge, decoded outputs one more
   sequence s_far_lands;
      ##1 {narrow_video, inband_audio} == $past(far_cfg_data[2:1], 2);
   endsequence
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_read: assert property (pready && pslverr && !pwrite |-> prdata == 32'h00000000)
      else $error("refused read returned data");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("prdata upper bits set");
   a_prot_pass: assert property (protection_enable != colour_passthrough)
      else $error("protection not opposite passthrough");
   a_pass_audio: assert property (colour_passthrough |->
      !packet_audio_enable && !audio_on_video_pins)
      else $error("audio live during passthrough");
   a_far_load: assert property (s_far_take |=> s_far_lands)
      else $error("far load not applied");
   a_hold_block: assert property (far_cfg_valid && hold_next && !wr_vp |=> ##1 $stable(narrow_video))
      else $error("far load leaked through hold");
endmodule // pin_video_cfg_asserts

// file: verif/far_end_model.sv
`timescale 1ns/1ps
// Far serializer: pin levels and one-cycle config pulses
module far_end_model (
   input logic clk,
   output logic [3:0] far_pin_level,
   output logic far_cfg_valid,
   output logic [6:0] far_cfg_data
);
   initial begin
      far_pin_level = 4'h0;
      far_cfg_valid = 1'b0;
      far_cfg_data = 7'h00;
   end
   // Data flipped after the pulse so stale bits never pass for valid
   task send(input logic [6:0] d);
      @(posedge clk);
      far_cfg_valid <= 1'b1;
      far_cfg_data <= d;
      @(posedge clk);
      far_cfg_valid <= 1'b0;
      far_cfg_data <= ~d;
   endtask
   task pins(input logic [3:0] v);
      @(posedge clk);
      far_pin_level <= v;
   endtask
endmodule // far_end_model

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "pin_cfg_regs.vh"
// Bus tasks and table-driven checks of the bank
module testbench;
   localparam logic [31:0] A_P56 = `PINS_5_6_CONFIG_IDX * 4;
   localparam logic [31:0] A_P78 = `PINS_7_8_CONFIG_IDX * 4;
   localparam logic [31:0] A_VP = `VIDEO_PATH_CONTROL_IDX * 4;
   localparam logic [63:0] VP_SEQ = 64'h89888182_84C090A0; // Hold set in every step
   logic clk, rst, psel, penable, pwrite, pready, pslverr, frame_valid, far_cfg_valid, rd_e;
   logic [31:0] paddr, pwdata, prdata, rd_q;
   logic [3:0] far_pin_level, pad_out, pad_oe_n;
   logic [6:0] far_cfg_data;
   wire [7:0] vp_out; // Decoded video path outputs, one port per bit
   integer error_cnt = 0;
   integer num_checks = 0;
   integer i;
   pin_video_cfg uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .far_pin_level, .far_cfg_valid, .far_cfg_data, .pad_in(4'h0), .pad_out,
      .pad_oe_n, .frame_valid, .frame_valid_active(vp_out[7]), .colour_passthrough(vp_out[6]),
      .protection_enable(vp_out[5]), .packet_audio_enable(vp_out[4]),
      .audio_on_video_pins(vp_out[3]), .quad_audio_enable(vp_out[2]),
      .inband_audio(vp_out[1]), .narrow_video(vp_out[0]));
   far_end_model far (.clk, .far_pin_level, .far_cfg_valid, .far_cfg_data);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task results;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", nm, exp, got);
      end
   endtask
   // One transfer; an idle cycle always precedes the setup
   task apb(input logic w, input logic [31:0] a, d);
      integer n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd_q = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         error_cnt++;
         results;
      end
   endtask
   // Outputs trail the register by one edge
   task check_vp(input logic [7:0] v, input logic fv);
      @(posedge clk);
      #1;
      chk("decoded", {24'h0, fv ^ v[5], v[6], !v[6], !v[6], !v[4] && !v[6], v[3] && v[0],
         v[1], v[2]}, {24'h0, vp_out});
      apb(1'b0, A_VP, 32'h0);
      chk("video_path_control", {24'h0, v}, rd_q);
   endtask
   initial begin
      {rst, psel, penable, pwrite, frame_valid, paddr, pwdata} = {1'b1, 68'h0};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      chk("pad_oe_n", 32'hF, {28'h0, pad_oe_n});
      check_vp(8'h00, 1'b0);
      apb(1'b0, A_P56, 32'h0);
      chk("pins_5_6_config", 32'h0, rd_q);
      apb(1'b1, 32'h8C, 32'hFF);
      chk("unmapped err", 32'h1, {31'h0, rd_e});
      far.pins(4'hA);
      for (i = 0; i < 4; i++) begin
         apb(1'b1, A_P56, {24'h0, {2{4'h8 | i[3:0]}}});
         @(posedge clk);
         #1;
         chk("oe 5/6", {30'h0, {2{i[1]}}}, {30'h0, pad_oe_n[1:0]});
         if (!i[1]) chk("out 5/6", {30'h0, {2{i == 1}}}, {30'h0, pad_out[1:0]});
      end
      apb(1'b1, A_P78, 32'hFF);
      repeat (2) @(posedge clk);
      #1;
      chk("pads 7/8", 32'h2, {28'h0, pad_oe_n[3:2], pad_out[3:2]});
      apb(1'b0, A_P78, 32'h0);
      chk("pins_7_8_config", 32'hFE, rd_q);
      far.send(7'h2D);
      check_vp(8'h2D, 1'b0);
      far.send(7'h52);
      check_vp(8'h52, 1'b0);
      apb(1'b1, A_VP, 32'h80);
      far.send(7'h7F);
      check_vp(8'h80, 1'b0);
      for (i = 0; i < 8; i++) begin
         frame_valid <= i[0];
         apb(1'b1, A_VP, {24'h0, VP_SEQ[63 - 8 * i -: 8]});
         check_vp(VP_SEQ[63 - 8 * i -: 8], i[0]);
      end
      results;
   end
endmodule // testbench
bind pin_video_cfg pin_video_cfg_asserts chk_i (.clk, .rst, .psel, .penable, .pwrite,
   .pready, .pslverr, .paddr, .pwdata, .prdata, .far_cfg_valid, .far_cfg_data,
   .colour_passthrough, .protection_enable, .packet_audio_enable, .audio_on_video_pins,
   .inband_audio, .narrow_video);
